/* File: hw/dpra_pkg.sv */
// Shared constants and types for the dual port register access arbiter
package dpra_pkg;
  // Register space geometry
  localparam int unsigned REG_SPACE_BYTES = 4096;
  localparam int unsigned REG_WORDS = REG_SPACE_BYTES / 4;
  localparam int unsigned REG_AW = 12;
  localparam int unsigned REG_IW = 10;
  // Word indices of special registers and BAR bit positions
  localparam logic [9:0] BAR_IDX = 10'h004;
  localparam logic [9:0] CFG_ADDR_IDX = 10'h200;
  localparam logic [9:0] CFG_DATA_IDX = 10'h201;
  localparam int unsigned BAR_SPACE_BIT = 0;
  localparam int unsigned BAR_BASE_LSB = 12;
  // Config target address field layout
  localparam int unsigned CTA_TYPE_BIT = 0;
  localparam int unsigned CTA_REG_LSB = 2;
  localparam int unsigned CTA_FUNC_LSB = 8;
  localparam int unsigned CTA_DEV_LSB = 11;
  // Local bus transfer size codes
  localparam logic [1:0] SIZE_WORD = 2'h0;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_HALF = 2'h2;
  // Ownership request timeouts in local bus clocks
  localparam int unsigned OWN_REQ_TIMEOUT = 1024;
  localparam int unsigned OWN_IDLE_TIMEOUT = 32;
  localparam logic [10:0] OWN_REQ_LAST = 11'(OWN_REQ_TIMEOUT - 1);
  localparam logic [5:0] OWN_IDLE_LAST = 6'(OWN_IDLE_TIMEOUT - 1);
  // Strap synchroniser settle count
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  typedef enum logic {
    DPRA_OWN_PCI = 1'b0,
    DPRA_OWN_LOCAL = 1'b1
  } dpra_owner_t;

  typedef enum logic [1:0] {
    DPRA_PK_MEM = 2'b00,
    DPRA_PK_IO = 2'b01,
    DPRA_PK_CFG0 = 2'b10,
    DPRA_PK_CFG1 = 2'b11
  } dpra_pci_kind_t;

  typedef enum logic [1:0] {
    DPRA_CS_IDLE = 2'b00,
    DPRA_CS_BUSY = 2'b01,
    DPRA_CS_DONE = 2'b10
  } dpra_cfg_state_t;

  typedef struct packed {
    logic valid;
    dpra_pci_kind_t kind;
    logic idsel;
    logic write;
    logic [11:0] addr;
    logic [3:0] be_n;
    logic [31:0] wdata;
  } dpra_pci_req_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic burst;
    logic [1:0] size;
    logic [11:0] addr;
    logic [31:0] wdata;
  } dpra_lb_req_t;

  typedef struct packed {
    logic req;
    logic write;
    logic [31:0] ad;
    logic [3:0] be;
    logic [31:0] wdata;
  } dpra_cfg_cyc_t;
endpackage : dpra_pkg

/* File: hw/dpra_cfg_gen.sv */
// Configuration cycle generator run as a delayed transaction
`timescale 1ns/1ps
`default_nettype none
module dpra_cfg_gen
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Control from the arbiter
  input wire logic start_in,
  input wire logic write_in,
  input wire logic [31:0] target_in,
  input wire logic [3:0] be_in,
  input wire logic [31:0] wdata_in,
  input wire logic retire_in,
  // PCI master side
  output dpra_pkg::dpra_cfg_cyc_t cyc_out,
  input wire logic done_in,
  input wire logic mabort_in,
  input wire logic [31:0] rdata_in,
  // Status
  output dpra_pkg::dpra_cfg_state_t state_out,
  output logic mabort_out,
  output logic held_write_out,
  output logic [3:0] held_be_out,
  output logic [31:0] rdata_out
);
  import dpra_pkg::*;

  dpra_cfg_state_t state_r;
  logic [31:0] ad_nxt;
  logic [3:0] dev;

  // Type 1 passes the address through, type 0 decodes a one-hot IDSEL
  always_comb
  begin
    dev = target_in[CTA_DEV_LSB +: 4];
    if (target_in[CTA_TYPE_BIT])
      ad_nxt = target_in;
    else
      ad_nxt = {16'h0001 << dev, 5'h00, target_in[CTA_FUNC_LSB +: 3],
                target_in[CTA_REG_LSB +: 6], 2'h0};
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      state_r <= DPRA_CS_IDLE;
    else
      unique case (state_r)
        DPRA_CS_IDLE: if (start_in) state_r <= DPRA_CS_BUSY;
        DPRA_CS_BUSY: if (done_in) state_r <= DPRA_CS_DONE;
        DPRA_CS_DONE: if (retire_in) state_r <= DPRA_CS_IDLE;
        default: state_r <= DPRA_CS_IDLE;
      endcase
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cyc_out <= '0;
      held_write_out <= 1'b0;
      held_be_out <= 4'h0;
    end
    else if (state_r == DPRA_CS_IDLE && start_in)
    begin
      cyc_out <= '{req: 1'b1, write: write_in, ad: ad_nxt, be: be_in,
                   wdata: wdata_in};
      held_write_out <= write_in;
      held_be_out <= be_in;
    end
    else if (done_in)
      cyc_out.req <= 1'b0;
  end

  // Read data is kept here until the matching retry collects it
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rdata_out <= 32'h0000_0000;
      mabort_out <= 1'b0;
    end
    else if (state_r == DPRA_CS_BUSY && done_in)
    begin
      rdata_out <= rdata_in;
      mabort_out <= mabort_in;
    end
  end

  assign state_out = state_r;

  property p_type0_addr;
    @(posedge clk_in) disable iff (rst_in)
    (state_r == DPRA_CS_IDLE && start_in && !target_in[CTA_TYPE_BIT])
    |=> cyc_out.req && cyc_out.ad[15:11] == 5'h00 && cyc_out.ad[1:0] == 2'h0
        && $onehot(cyc_out.ad[31:16]);
  endproperty
  a_type0_addr: assert property (p_type0_addr)
    else $error("type 0 address phase malformed");
endmodule : dpra_cfg_gen
`default_nettype wire

/* File: hw/dpra_arbiter.sv */
// Register port arbiter shared by the PCI target and the local bus slave
`timescale 1ns/1ps
`default_nettype none
module dpra_arbiter
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // PCI target side
  input wire dpra_pkg::dpra_pci_req_t pci_req_in,
  output logic pci_ack_out,
  output logic pci_retry_out,
  output logic [31:0] pci_rdata_out,
  // Local bus slave side
  input wire dpra_pkg::dpra_lb_req_t lb_req_in,
  output logic lb_ack_out,
  output logic lb_retry_out,
  output logic lb_berr_out,
  output logic [31:0] lb_rdata_out,
  // Configuration cycle master
  output dpra_pkg::dpra_cfg_cyc_t cfg_cyc_out,
  input wire logic cfg_done_in,
  input wire logic cfg_mabort_in,
  input wire logic [31:0] cfg_rdata_in,
  // Control and status bits
  input wire logic park_at_last_owner_in,
  input wire logic mem_space_en_in,
  input wire logic bus_master_enable_in,
  input wire logic master_abort_hide_in,
  input wire logic pci_hold_strap_in,
  input wire logic pci_hold_clear_in,
  input wire logic eeprom_busy_in,
  input wire logic eeprom_hold_load_in,
  input wire logic eeprom_hold_value_in,
  output logic pci_access_hold_out,
  output logic local_owns_out,
  output logic [19:0] register_base_address_out
);
  import dpra_pkg::*;

  logic [31:0] regs_r [0:REG_WORDS-1];
  dpra_owner_t owner_r;
  logic lreq_r;
  logic preq_r;
  logic [10:0] req_age_r;
  logic [5:0] idle_age_r;
  logic idle_arm_r;
  logic [2:0] strap_sync_r;
  logic [1:0] strap_age_r;
  logic strap_done_r;
  logic hold_r;
  dpra_cfg_state_t cfg_state;
  logic cfg_mabort, cfg_held_write;
  logic [3:0] cfg_held_be;
  logic [31:0] cfg_rdata;
  logic pci_claim, pci_go, pci_own_retry, pci_retry;
  logic [9:0] pci_idx;
  logic [3:0] pci_lanes, lb_lanes;
  logic lb_cfgd, lb_go, lb_own_retry, lb_retry, lb_berr, lb_ack;
  logic cfg_start, cfg_retire, cfg_match;
  logic [9:0] lb_idx;
  logic wr_en;
  logic [9:0] wr_idx;
  logic [3:0] wr_lanes;
  logic [31:0] wr_data;
  logic [31:0] pci_word, lb_word, pci_mask, lb_mask;
  logic any_access;

  // Byte offset zero sits on the top lane for byte and halfword transfers
  function automatic logic [3:0] size_lanes(input logic [1:0] sz,
                                            input logic [1:0] a);
    unique case (sz)
      SIZE_BYTE: size_lanes = 4'h8 >> a;
      SIZE_HALF: size_lanes = a[1] ? 4'h3 : 4'hC;
      default: size_lanes = 4'hF;
    endcase
  endfunction : size_lanes

  // PCI decode: memory needs the enable, type 0 needs IDSEL
  always_comb
  begin
    pci_claim = pci_req_in.valid &&
      ((pci_req_in.kind == DPRA_PK_MEM && mem_space_en_in) ||
       (pci_req_in.kind == DPRA_PK_CFG0 && pci_req_in.idsel));
    pci_idx = (pci_req_in.kind == DPRA_PK_CFG0) ?
      {4'h0, pci_req_in.addr[7:2]} : pci_req_in.addr[11:2];
    pci_lanes = ~pci_req_in.be_n;
    pci_own_retry = pci_claim && owner_r == DPRA_OWN_LOCAL;
    pci_retry = pci_claim && (hold_r || eeprom_busy_in ||
                              pci_own_retry);
    pci_go = pci_claim && !pci_retry;
  end

  // Local decode including the delayed configuration data port
  always_comb
  begin
    lb_idx = lb_req_in.addr[11:2];
    lb_lanes = size_lanes(lb_req_in.size, lb_req_in.addr[1:0]);
    lb_cfgd = lb_idx == CFG_DATA_IDX;
    lb_berr = 1'b0;
    lb_retry = 1'b0;
    lb_own_retry = 1'b0;
    lb_go = 1'b0;
    cfg_start = 1'b0;
    cfg_retire = 1'b0;
    cfg_match = cfg_held_write == lb_req_in.write && cfg_held_be == lb_lanes;
    if (lb_req_in.valid)
    begin
      if (lb_req_in.burst)
        lb_berr = 1'b1;
      else if (owner_r != DPRA_OWN_LOCAL)
      begin
        lb_retry = 1'b1;
        lb_own_retry = 1'b1;
      end
      else if (lb_cfgd)
      begin
        lb_retry = !(cfg_state == DPRA_CS_DONE && cfg_match);
        cfg_start = cfg_state == DPRA_CS_IDLE;
        cfg_retire = !lb_retry;
        lb_berr = cfg_retire && cfg_mabort && !master_abort_hide_in;
      end
      else
        lb_go = 1'b1;
    end
    lb_ack = lb_go || (cfg_retire && !lb_berr);
    any_access = pci_req_in.valid || lb_req_in.valid;
  end

  // Only the owner can write, so one write port is enough
  always_comb
  begin
    wr_en = (pci_go && pci_req_in.write) || (lb_go && lb_req_in.write);
    wr_idx = pci_go ? pci_idx : lb_idx;
    wr_lanes = pci_go ? pci_lanes : lb_lanes;
    wr_data = pci_go ? pci_req_in.wdata : lb_req_in.wdata;
  end

  always_ff @(posedge clk_in)
  begin
    if (wr_en)
      for (int i = 0; i < 4; i++)
        if (wr_lanes[i])
          regs_r[wr_idx][8*i +: 8] <= wr_data[8*i +: 8];
  end

  // Space indicator is forced to memory
  always_comb
  begin
    pci_word = regs_r[pci_idx];
    lb_word = regs_r[lb_idx];
    if (pci_idx == BAR_IDX)
      pci_word[BAR_SPACE_BIT] = 1'b0;
    if (lb_idx == BAR_IDX)
      lb_word[BAR_SPACE_BIT] = 1'b0;
    if (lb_cfgd)
      lb_word = cfg_rdata;
  end

  for (genvar g = 0; g < 4; g++)
  begin : g_lane
    assign pci_mask[8*g +: 8] = {8{pci_lanes[g]}};
    assign lb_mask[8*g +: 8] = {8{lb_lanes[g]}};
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pci_ack_out <= 1'b0;
      pci_retry_out <= 1'b0;
      pci_rdata_out <= 32'h0000_0000;
    end
    else
    begin
      pci_ack_out <= pci_go;
      pci_retry_out <= pci_retry;
      if (pci_go && !pci_req_in.write)
        pci_rdata_out <= pci_word & pci_mask;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      lb_ack_out <= 1'b0;
      lb_retry_out <= 1'b0;
      lb_berr_out <= 1'b0;
      lb_rdata_out <= 32'h0000_0000;
    end
    else
    begin
      lb_ack_out <= lb_ack;
      lb_retry_out <= lb_retry;
      lb_berr_out <= lb_berr;
      if (lb_ack && !lb_req_in.write)
        lb_rdata_out <= lb_word & lb_mask;
    end
  end

  // Local ownership request with its two withdrawal timers
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      lreq_r <= 1'b0;
      req_age_r <= 11'h000;
      idle_age_r <= 6'h00;
      idle_arm_r <= 1'b0;
    end
    else
    begin
      if (lb_req_in.valid)
      begin
        req_age_r <= 11'h000;
        idle_age_r <= 6'h00;
        idle_arm_r <= lb_ack;
        if (lb_own_retry)
          lreq_r <= 1'b1;
      end
      else if (lreq_r)
      begin
        req_age_r <= req_age_r + 11'h001;
        if (idle_arm_r && !park_at_last_owner_in)
          idle_age_r <= idle_age_r + 6'h01;
        if (req_age_r == OWN_REQ_LAST)
          lreq_r <= 1'b0;
        if (idle_arm_r && !park_at_last_owner_in &&
            idle_age_r == OWN_IDLE_LAST)
          lreq_r <= 1'b0;
        // Parked hand-back to PCI consumes the request, so no ping-pong
        if (!pci_req_in.valid && owner_r == DPRA_OWN_LOCAL &&
            park_at_last_owner_in && preq_r)
          lreq_r <= 1'b0;
      end
    end
  end

  // Ownership pointer moves only in cycles with no access present
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      owner_r <= DPRA_OWN_PCI;
      preq_r <= 1'b0;
    end
    else
    begin
      if (pci_own_retry)
        preq_r <= 1'b1;
      if (!any_access)
        unique case (owner_r)
          DPRA_OWN_PCI:
            if (lreq_r)
              owner_r <= DPRA_OWN_LOCAL;
          DPRA_OWN_LOCAL:
            if (park_at_last_owner_in ? preq_r : !lreq_r)
            begin
              owner_r <= DPRA_OWN_PCI;
              preq_r <= 1'b0;
            end
        endcase
    end
  end

  // Strap passes three stages and is taken once it has settled
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      strap_sync_r <= 3'h0;
      strap_age_r <= 2'h0;
    end
    else
    begin
      strap_sync_r <= {strap_sync_r[1:0], pci_hold_strap_in};
      if (strap_age_r != STRAP_SETTLE)
        strap_age_r <= strap_age_r + 2'h1;
    end
  end

  // Hardware loads win over a same-cycle software clear
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      hold_r <= 1'b1;
      strap_done_r <= 1'b0;
    end
    else
    begin
      if (pci_hold_clear_in)
        hold_r <= 1'b0;
      if (eeprom_hold_load_in)
        hold_r <= eeprom_hold_value_in;
      if (!strap_done_r && strap_age_r == STRAP_SETTLE &&
          strap_sync_r[1] == strap_sync_r[2])
      begin
        hold_r <= strap_sync_r[2] || eeprom_hold_load_in &&
                  eeprom_hold_value_in;
        strap_done_r <= 1'b1;
      end
    end
  end

  dpra_cfg_gen u_cfg
  (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .start_in(cfg_start),
    .write_in(lb_req_in.write),
    .target_in(regs_r[CFG_ADDR_IDX]),
    .be_in(lb_lanes),
    .wdata_in(lb_req_in.wdata),
    .retire_in(cfg_retire),
    .cyc_out(cfg_cyc_out),
    .done_in(cfg_done_in),
    .mabort_in(cfg_mabort_in),
    .rdata_in(cfg_rdata_in),
    .state_out(cfg_state),
    .mabort_out(cfg_mabort),
    .held_write_out(cfg_held_write),
    .held_be_out(cfg_held_be),
    .rdata_out(cfg_rdata)
  );

  assign pci_access_hold_out = hold_r;
  assign local_owns_out = owner_r == DPRA_OWN_LOCAL;
  assign register_base_address_out = regs_r[BAR_IDX][31:BAR_BASE_LSB];

  logic [11:0] chk_idle_r;
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      chk_idle_r <= 12'h000;
    else
      chk_idle_r <= (lreq_r && !lb_req_in.valid) ?
                    chk_idle_r + 12'h001 : 12'h000;
  end

  property p_pci_retry_local;
    @(posedge clk_in) disable iff (rst_in)
    pci_claim && local_owns_out |=> pci_retry_out && !pci_ack_out;
  endproperty
  a_pci_retry_local: assert property (p_pci_retry_local)
    else $error("PCI access not retried while local bus owns the port");
  property p_hold_retry;
    @(posedge clk_in) disable iff (rst_in)
    pci_claim && (hold_r || eeprom_busy_in) |=> pci_retry_out && !pci_ack_out;
  endproperty
  a_hold_retry: assert property (p_hold_retry)
    else $error("PCI access accepted during hold or EEPROM load");
  property p_io_ignored;
    @(posedge clk_in) disable iff (rst_in)
    pci_req_in.valid && pci_req_in.kind == DPRA_PK_IO
    |=> !pci_ack_out && !pci_retry_out;
  endproperty
  a_io_ignored: assert property (p_io_ignored)
    else $error("I/O access was answered");
  property p_burst_berr;
    @(posedge clk_in) disable iff (rst_in)
    lb_req_in.valid && lb_req_in.burst |=> lb_berr_out && !lb_ack_out;
  endproperty
  a_burst_berr: assert property (p_burst_berr)
    else $error("local burst did not end in bus error");
  property p_lb_retry_raise;
    @(posedge clk_in) disable iff (rst_in)
    lb_req_in.valid && !lb_req_in.burst && !local_owns_out
    |=> lb_retry_out && lreq_r;
  endproperty
  a_lb_retry_raise: assert property (p_lb_retry_raise)
    else $error("local access without ownership not retried");
  property p_owner_stable;
    @(posedge clk_in) disable iff (rst_in)
    any_access |=> $stable(local_owns_out);
  endproperty
  a_owner_stable: assert property (p_owner_stable)
    else $error("ownership changed during an access");
  property p_req_timeout;
    @(posedge clk_in) disable iff (rst_in)
    chk_idle_r <= 12'h400;
  endproperty
  a_req_timeout: assert property (p_req_timeout)
    else $error("ownership request outlived its timeout");
  property p_park_stays;
    @(posedge clk_in) disable iff (rst_in)
    park_at_last_owner_in && local_owns_out && !preq_r && !pci_claim
    |=> local_owns_out;
  endproperty
  a_park_stays: assert property (p_park_stays)
    else $error("parked port left the local bus unasked");
  c_switch_local: cover property (@(posedge clk_in) $rose(local_owns_out));
  c_cfg_done: cover property (@(posedge clk_in) cfg_retire);
  c_pci_ack: cover property (@(posedge clk_in) pci_ack_out);
endmodule : dpra_arbiter
`default_nettype wire

/* File: sim/dpra_cfg_tgt.sv */
// Far-side PCI configuration target that answers generated cycles
`timescale 1ns/1ps
`default_nettype none
module dpra_cfg_tgt
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Cycle in and scenario controls
  input wire dpra_pkg::dpra_cfg_cyc_t cyc_in,
  input wire logic [3:0] wait_in,
  input wire logic abort_in,
  // Completion out
  output logic done_out,
  output logic mabort_out,
  output logic [31:0] rdata_out
);
  import dpra_pkg::*;
  logic [3:0] cnt_r;
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt_r <= 4'h0;
      done_out <= 1'b0;
      mabort_out <= 1'b0;
      rdata_out <= 32'h0;
    end
    else
    begin
      // Data lines keep toggling outside completion
      rdata_out <= ~rdata_out;
      done_out <= 1'b0;
      mabort_out <= 1'b0;
      cnt_r <= 4'h0;
      if (cyc_in.req && !done_out)
      begin
        cnt_r <= cnt_r + 4'h1;
        if (cnt_r == wait_in)
        begin
          done_out <= 1'b1;
          mabort_out <= abort_in;
          rdata_out <= cyc_in.ad ^ 32'hA5A5_0000;
        end
      end
    end
  end
endmodule : dpra_cfg_tgt
`default_nettype wire

/* File: sim/dpra_arbiter_tb_top.sv */
// Self-checking bench for the register access arbiter
`timescale 1ns/1ps
`default_nettype none
module dpra_arbiter_tb_top;
  import dpra_pkg::*;
  logic clk_in, rst_in, pa, pr, la, lr, lbe, dn, mab, park, mse, bme;
  logic hide, strap, hclr, ebz, eld, evl, hold, lown, abt, sel, a, r, e;
  logic [31:0] prd, lrd, crd, d;
  logic [19:0] bar;
  logic [3:0] wt;
  dpra_pci_req_t pq;
  dpra_lb_req_t lq;
  dpra_cfg_cyc_t cyc;
  int n_errors, total_checks, ncyc;
  dpra_arbiter i_dut (.clk_in(clk_in), .rst_in(rst_in), .pci_req_in(pq),
    .pci_ack_out(pa), .pci_retry_out(pr), .pci_rdata_out(prd),
    .lb_req_in(lq), .lb_ack_out(la), .lb_retry_out(lr), .lb_berr_out(lbe),
    .lb_rdata_out(lrd), .cfg_cyc_out(cyc), .cfg_done_in(dn),
    .cfg_mabort_in(mab), .cfg_rdata_in(crd), .park_at_last_owner_in(park),
    .mem_space_en_in(mse), .bus_master_enable_in(bme),
    .master_abort_hide_in(hide), .pci_hold_strap_in(strap),
    .pci_hold_clear_in(hclr), .eeprom_busy_in(ebz),
    .eeprom_hold_load_in(eld), .eeprom_hold_value_in(evl),
    .pci_access_hold_out(hold), .local_owns_out(lown),
    .register_base_address_out(bar));
  dpra_cfg_tgt i_far (.clk_in(clk_in), .rst_in(rst_in), .cyc_in(cyc),
    .wait_in(wt), .abort_in(abt), .done_out(dn), .mabort_out(mab),
    .rdata_out(crd));
  initial
  begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  always @(posedge clk_in)
  begin
    ncyc++;
    if (ncyc == 4000)
    begin
      n_errors++;
      $display("mismatch at %0t: run too long", $time);
      summarize();
    end
  end
  task automatic summarize();
    if (n_errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic gap(input int n);
    repeat (n) @(negedge clk_in);
  endtask : gap
  // One PCI request, answer sampled a cycle later, then an idle cycle
  task automatic pci(input dpra_pci_kind_t k, input logic w,
    input logic [11:0] ad, input logic [3:0] ben, input logic [31:0] wd);
    pq <= '{1'b1, k, sel, w, ad, ben, wd};
    @(negedge clk_in);
    pq.valid <= 1'b0;
    a = pa;
    r = pr;
    d = prd;
    @(negedge clk_in);
  endtask : pci
  task automatic lbt(input logic w, input logic bu, input logic [1:0] sz,
    input logic [11:0] ad, input logic [31:0] wd);
    lq <= '{1'b1, w, bu, sz, ad, wd};
    @(negedge clk_in);
    lq.valid <= 1'b0;
    a = la;
    r = lr;
    e = lbe;
    d = lrd;
    @(negedge clk_in);
  endtask : lbt
  task automatic unhold();
    hclr = 1'b1;
    gap(1);
    hclr = 1'b0;
    gap(1);
  endtask : unhold
  task automatic t_hold();
    gap(6);
    chk(32'({hold, lown}), 32'h2);
    pci(DPRA_PK_MEM, 1'b0, 12'h008, 4'h0, 32'h0);
    chk(32'({a, r}), 32'h1);
    unhold();
    chk(32'(hold), 32'h0);
    ebz = 1'b1;
    pci(DPRA_PK_MEM, 1'b0, 12'h008, 4'h0, 32'h0);
    ebz = 1'b0;
    chk(32'({a, r}), 32'h1);
    {eld, evl} = 2'h3;
    gap(1);
    eld = 1'b0;
    pci(DPRA_PK_MEM, 1'b0, 12'h008, 4'h0, 32'h0);
    chk(32'({hold, a, r}), 32'h5);
    unhold();
  endtask : t_hold
  task automatic t_mem();
    pci(DPRA_PK_MEM, 1'b1, 12'h008, 4'h0, 32'h1122_3344);
    chk(32'({a, r}), 32'h2);
    pci(DPRA_PK_MEM, 1'b0, 12'h008, 4'hD, 32'h0);
    chk(d, 32'h0000_3300);
    pci(DPRA_PK_CFG0, 1'b0, 12'hF08, 4'h0, 32'h0);
    chk(d, 32'h1122_3344);
    sel = 1'b0;
    pci(DPRA_PK_CFG0, 1'b0, 12'h008, 4'h0, 32'h0);
    sel = 1'b1;
    chk(32'({a, r}), 32'h0);
    pci(DPRA_PK_IO, 1'b0, 12'h008, 4'h0, 32'h0);
    chk(32'({a, r}), 32'h0);
    mse = 1'b0;
    pci(DPRA_PK_MEM, 1'b0, 12'h008, 4'h0, 32'h0);
    mse = 1'b1;
    chk(32'({a, r}), 32'h0);
    pci(DPRA_PK_MEM, 1'b1, 12'h010, 4'h0, 32'hFFFF_F001);
    pci(DPRA_PK_MEM, 1'b0, 12'h010, 4'h0, 32'h0);
    chk(d, 32'hFFFF_F000);
    chk(32'(bar), 32'h000F_FFFF);
  endtask : t_mem
  task automatic t_local();
    lbt(1'b0, 1'b0, SIZE_BYTE, 12'h00A, 32'h0);
    chk(32'({a, r, e}), 32'h2);
    gap(1);
    chk(32'(lown), 32'h1);
    lbt(1'b0, 1'b0, SIZE_BYTE, 12'h00A, 32'h0);
    chk(d & 32'h0000_FF00, 32'h0000_3300);
    lbt(1'b1, 1'b0, SIZE_WORD, 12'h00C, 32'hCAFE_F00D);
    lbt(1'b0, 1'b0, SIZE_HALF, 12'h00C, 32'h0);
    chk(d & 32'hFFFF_0000, 32'hCAFE_0000);
    gap(20);
    chk(32'(lown), 32'h1);
    pci(DPRA_PK_MEM, 1'b0, 12'h00C, 4'h0, 32'h0);
    chk(32'({a, r}), 32'h1);
    gap(20);
    pci(DPRA_PK_MEM, 1'b0, 12'h00C, 4'h0, 32'h0);
    chk(d, 32'hCAFE_F00D);
  endtask : t_local
  task automatic t_timeout();
    lbt(1'b0, 1'b0, SIZE_WORD, 12'h00C, 32'h0);
    gap(1000);
    chk(32'({r, lown}), 32'h3);
    gap(60);
    chk(32'(lown), 32'h0);
  endtask : t_timeout
  task automatic t_park();
    park = 1'b1;
    lbt(1'b0, 1'b0, SIZE_WORD, 12'h00C, 32'h0);
    gap(1);
    lbt(1'b0, 1'b0, SIZE_WORD, 12'h00C, 32'h0);
    gap(60);
    chk(32'(lown), 32'h1);
    lbt(1'b0, 1'b0, SIZE_WORD, 12'h00C, 32'h0);
    chk(32'({a, r, e}), 32'h4);
    lbt(1'b0, 1'b1, SIZE_WORD, 12'h00C, 32'h0);
    chk(32'({a, r, e}), 32'h1);
    pci(DPRA_PK_MEM, 1'b0, 12'h00C, 4'h0, 32'h0);
    chk(32'({a, r}), 32'h1);
    gap(1);
    pci(DPRA_PK_MEM, 1'b0, 12'h00C, 4'h0, 32'h0);
    chk(32'({a, r}), 32'h2);
    gap(60);
    chk(32'(lown), 32'h0);
    park = 1'b0;
  endtask : t_park
  task automatic cfg(input logic [31:0] ca, input logic [31:0] ead,
    input logic ab, input logic wr);
    int i;
    logic ee;
    ee = ab & ~hide;
    abt = ab;
    a = 1'b0;
    for (i = 0; i < 4 && a !== 1'b1; i++)
      lbt(1'b1, 1'b0, SIZE_WORD, 12'h800, ca);
    chk(32'(a), 32'h1);
    lbt(wr, 1'b0, SIZE_WORD, 12'h804, 32'h5A5A_1234);
    chk(32'({a, r, cyc.req, cyc.write}), 32'({3'h3, wr}));
    chk(cyc.ad, ead);
    chk(cyc.wdata, 32'h5A5A_1234);
    chk(32'(cyc.be), 32'hF);
    for (i = 0; i < 16 && r === 1'b1; i++)
      lbt(wr, 1'b0, SIZE_WORD, 12'h804, 32'h5A5A_1234);
    chk(32'({a, e}), 32'({~ee, ee}));
    if (!ab && !wr)
      chk(d, ead ^ 32'hA5A5_0000);
  endtask : cfg
  task automatic t_cfg();
    bme = 1'b1;
    cfg(32'h0000_1A14, 32'h0008_0214, 1'b0, 1'b0);
    wt = 4'h9;
    cfg(32'h0000_7FFC, 32'h8000_07FC, 1'b0, 1'b0);
    wt = 4'h0;
    cfg(32'h00AB_CD01, 32'h00AB_CD01, 1'b0, 1'b0);
    cfg(32'h0012_3401, 32'h0012_3401, 1'b1, 1'b0);
    hide = 1'b1;
    cfg(32'h0012_3401, 32'h0012_3401, 1'b1, 1'b0);
    cfg(32'h0012_3401, 32'h0012_3401, 1'b0, 1'b1);
  endtask : t_cfg
  initial
  begin
    pq = '0;
    lq = '0;
    {park, bme, hide, hclr, ebz, eld, evl, abt} = 8'h00;
    {strap, sel, mse, rst_in} = 4'hF;
    wt = 4'h3;
    repeat (6) @(negedge clk_in);
    rst_in = 1'b0;
    t_hold();
    t_mem();
    t_local();
    t_timeout();
    t_park();
    t_cfg();
    summarize();
  end
endmodule : dpra_arbiter_tb_top
`default_nettype wire
